// ==== pmic_ctrl_regs.svh ====
// Register offsets, reset values, field positions and timing constants of the control block.
`ifndef PMIC_CTRL_REGS_SVH
`define PMIC_CTRL_REGS_SVH

// ****************************************************************
// Serial bus address and sub-addresses
// ****************************************************************
`define DEV_ADDR7 7'h09
`define SUB_NONE 8'h00
`define SUB_BUCK1 8'h01
`define SUB_BUCK4 8'h04
`define SUB_BOOST 8'h05
`define SUB_BUCKBOOST 8'h06
`define SUB_LED_DRIVE_CONFIG 8'h07
`define SUB_LED_BRIGHTNESS_CODE 8'h08
`define SUB_UVOT 8'h09
`define SUB_RESET_MASK 8'h0a
`define SUB_IRQ_MASK 8'h0b
`define SUB_STATUS_LIVE 8'h0c
`define SUB_STATUS_LATCHED 8'h0d
`define SUB_CLEAR_IRQ 8'h0f
`define SUB_LAST_RW 8'h0b

// ****************************************************************
// Reset values
// ****************************************************************
`define DEF_BUCK 8'h6f
`define DEF_BOOST 8'h0f
`define DEF_BUCKBOOST 8'h0f
`define DEF_LED_DRIVE_CONFIG 8'h0f
`define DEF_LED_BRIGHTNESS_CODE 8'h00
`define DEF_UVOT 8'h00
`define DEF_RESET_MASK 8'hff
`define DEF_IRQ_MASK 8'h00
`define DEF_ZERO 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_ENABLE 7
`define BIT_DOUBLE_SCALE 3
`define BIT_RESET_ALL 7
`define BIT_RW 0
`define BYTE_BITS 4'h8

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ 20000000
`define TICK_MS 1
`define PRESS_MS 400
`define WAKE_MS 5000
`define HARD_PRESS_MS 5000
`define HARD_OFF_MS 1000
`define POR_DELAY_MS 200

`endif

// ==== pmic_ctrl_pkg.sv ====
// Types shared by the power control and serial port logic.
package pmic_ctrl_pkg;

  typedef logic [11:0][7:0] bank_t;

  typedef enum logic [2:0] {
    PS_IDLE,
    PS_RX,
    PS_ACK,
    PS_TX,
    PS_MACK
  } port_state_e;

  typedef enum logic [1:0] {
    BK_ADDR,
    BK_SUB,
    BK_DATA
  } byte_kind_e;

  typedef struct packed {
    logic scl_m;
    logic scl_y;
    logic [2:0] scl_h;
    logic scl_f;
    logic sda_m;
    logic sda_y;
    logic [2:0] sda_h;
    logic sda_f;
    logic io_m;
    logic io_y;
    logic hr_m;
    logic hr_y;
    logic hr_p;
    logic [3:0] pg_m;
    logic [3:0] pg_y;
    port_state_e st;
    byte_kind_e kind;
    logic to_tx;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic pending;
    logic commit_tgl;
    logic sda_oe;
    logic sda_o;
    bank_t hold;
  } link_state_s;

  typedef struct packed {
    logic pb_m;
    logic pb_y;
    logic [4:0] en_m;
    logic [4:0] en_y;
    logic io_m;
    logic io_y;
    logic cm_m;
    logic cm_y;
    logic cm_p;
    logic [3:0] pg_m;
    logic [3:0] pg_y;
    logic [15:0] div;
    logic [15:0] pb_cnt;
    logic wake;
    logic [15:0] wake_cnt;
    logic hr_off;
    logic [15:0] hr_cnt;
    logic por_n;
    logic [15:0] por_cnt;
    logic hr_tgl;
    logic btn;
    logic [5:0] reg_en;
    bank_t cmd;
  } ctrl_state_s;

endpackage : pmic_ctrl_pkg

// ==== pmic_ctrl.sv ====
// Pushbutton, wake and hard-reset sequencer with a sub-addressed serial register port.
`timescale 1ns/10ps
`include "pmic_ctrl_regs.svh"

// Functional notes
// - From off, raise power hold on 400ms press or any regulator enable.
// - Power hold stays high 5 seconds, then drops by itself.
// - Further enables while already on do not raise power hold again.
// - On state means power hold high or any regulator enabled.
// - While on, button state output follows the pushbutton level.
// - On, a 5 second press forces regulators off 1s and loads defaults.
// - A bus command triggers the same hard reset.
// - Reset output releases 200ms after all enabled bucks are in regulation.
// - After hard-reset off time, pin-enabled regulators restart and hold rises.
// - LED current code is the 8-bit register at sub-address 8.
// - Bit 3 at sub-address 7 doubles LED current per step.
// - Low I/O supply resets the serial port and all registers.
// - Serial port runs up to 400kHz and filters input glitches.
// - Written data takes effect when the master sends STOP.
// - Bytes are 8 bits, MSB first, plus one acknowledge clock.
// - Write acknowledges address and following bytes; read acknowledges address only.
// - Acknowledge holds SDA low across the acknowledge clock high phase.
// - Read returns one byte then releases SDA; master acknowledge ignored.
// - Device answers 7-bit address 0001001, write 12h and read 13h.
// - Write is address, sub-address, data; clear-interrupt write has no data.
// - Data waits in holding latches, moved to command latches on STOP.
// - Interrupt clear is a 0Fh write with STOP, then 00h with STOP.
// - Several sub-address and data pairs may follow one address.
module pmic_ctrl
  import pmic_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = (`CLK_HZ / 1000) * `TICK_MS,
  parameter int PRESS_TICKS = `PRESS_MS / `TICK_MS,
  parameter int WAKE_TICKS = `WAKE_MS / `TICK_MS,
  parameter int HARD_PRESS_TICKS = `HARD_PRESS_MS / `TICK_MS,
  parameter int HARD_OFF_TICKS = `HARD_OFF_MS / `TICK_MS,
  parameter int POR_TICKS = `POR_DELAY_MS / `TICK_MS
) (
  input wire logic clk, // System clock, 20 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic link_clk, // Sampling clock of the serial port.
  input wire logic pushbutton_in_n, // Pushbutton, low when pressed.
  input wire logic [4:0] enable_pin, // Enable pins: buck1..4, buck-boost.
  input wire logic [3:0] output_in_regulation, // Buck outputs in regulation.
  input wire logic io_supply, // High while the I/O supply is above 1V.
  input wire logic scl_in, // Serial clock level.
  input wire logic sda_in, // Serial data level.
  output logic sda_out, // Serial data drive value, always low.
  output logic sda_oe, // Serial data pull-down enable.
  output logic power_hold_out, // Timed power hold pulse.
  output logic button_state_out, // Pushbutton level while on.
  output logic power_on_reset_out_n, // Power-on reset, low while held.
  output logic [5:0] regulator_en_out, // Buck1..4, boost, buck-boost enables.
  output logic [7:0] led_brightness_code_out, // LED current code.
  output logic led_double_scale_out, // LED double scale select.
  output bank_t command_out // All command latches.
);

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  function automatic bank_t bank_defaults();
    bank_t b;
    b = '0;
    for (int i = 1; i <= 4; i++) begin
      b[i] = `DEF_BUCK;
    end
    b[`SUB_BOOST] = `DEF_BOOST;
    b[`SUB_BUCKBOOST] = `DEF_BUCKBOOST;
    b[`SUB_LED_DRIVE_CONFIG] = `DEF_LED_DRIVE_CONFIG;
    b[`SUB_LED_BRIGHTNESS_CODE] = `DEF_LED_BRIGHTNESS_CODE;
    b[`SUB_UVOT] = `DEF_UVOT;
    b[`SUB_RESET_MASK] = `DEF_RESET_MASK;
    b[`SUB_IRQ_MASK] = `DEF_IRQ_MASK;
    return b;
  endfunction : bank_defaults

  function automatic logic [15:0] tick_count(input logic [15:0] c, input logic run,
                                             input logic tick);
    logic [15:0] r;
    r = c;
    if (!run) begin
      r = '0;
    end else if (tick && c != 16'hffff) begin
      r = c + 16'h0001;
    end
    return r;
  endfunction : tick_count

  // ****************************************************************
  // Link domain reset
  // ****************************************************************
  // Reset asserts at once but releases on the link clock, so the port never
  // leaves reset in the middle of a link clock edge.
  logic lrst_m;
  logic lrst;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lrst_m <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_m <= 1'b0;
      lrst <= lrst_m;
    end
  end

  // ****************************************************************
  // Serial port, link domain
  // ****************************************************************
  link_state_s lq;
  link_state_s ld;
  ctrl_state_s cq;
  ctrl_state_s cd;

  always_comb begin
    logic scl_r;
    logic scl_fl;
    logic start_c;
    logic stop_c;
    logic [7:0] rd_byte;
    scl_r = 1'b0;
    scl_fl = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    rd_byte = '0;
    ld = lq;
    ld.scl_m = scl_in;
    ld.scl_y = lq.scl_m;
    ld.sda_m = sda_in;
    ld.sda_y = lq.sda_m;
    ld.io_m = io_supply;
    ld.io_y = lq.io_m;
    ld.hr_m = cq.hr_tgl;
    ld.hr_y = lq.hr_m;
    ld.hr_p = lq.hr_y;
    ld.pg_m = output_in_regulation;
    ld.pg_y = lq.pg_m;
    ld.scl_h = {lq.scl_h[1:0], lq.scl_y};
    ld.sda_h = {lq.sda_h[1:0], lq.sda_y};
    if (&lq.scl_h) begin
      ld.scl_f = 1'b1;
    end else if (~|lq.scl_h) begin
      ld.scl_f = 1'b0;
    end
    if (&lq.sda_h) begin
      ld.sda_f = 1'b1;
    end else if (~|lq.sda_h) begin
      ld.sda_f = 1'b0;
    end
    scl_r = ld.scl_f & ~lq.scl_f;
    scl_fl = ~ld.scl_f & lq.scl_f;
    start_c = lq.scl_f & ld.scl_f & lq.sda_f & ~ld.sda_f;
    stop_c = lq.scl_f & ld.scl_f & ~lq.sda_f & ld.sda_f;
    if (lq.ptr <= `SUB_LAST_RW) begin
      rd_byte = lq.hold[lq.ptr[3:0]];
    end
    if (lq.ptr == `SUB_NONE) begin
      rd_byte = `DEF_ZERO;
    end else if (lq.ptr == `SUB_STATUS_LIVE) begin
      rd_byte = {4'h0, lq.pg_y};
    end
    case (lq.st)
      PS_IDLE: begin
        ld.sda_oe = 1'b0;
      end
      PS_RX: begin
        if (scl_r) begin
          ld.sh = {lq.sh[6:0], lq.sda_f};
          ld.cnt = lq.cnt + 4'h1;
        end
        if (scl_fl && lq.cnt == `BYTE_BITS) begin
          ld.cnt = '0;
          ld.st = PS_ACK;
          ld.to_tx = 1'b0;
          ld.sda_oe = 1'b1;
          case (lq.kind)
            BK_ADDR: begin
              if (lq.sh[7:1] != `DEV_ADDR7) begin
                ld.st = PS_IDLE;
                ld.sda_oe = 1'b0;
              end else if (lq.sh[`BIT_RW]) begin
                ld.to_tx = 1'b1;
              end else begin
                ld.kind = BK_SUB;
              end
            end
            BK_SUB: begin
              ld.ptr = lq.sh;
              ld.kind = BK_DATA;
            end
            default: begin
              if (lq.ptr != `SUB_NONE && lq.ptr <= `SUB_LAST_RW) begin
                ld.hold[lq.ptr[3:0]] = lq.sh;
              end
              ld.pending = 1'b1;
              ld.kind = BK_SUB;
            end
          endcase
        end
      end
      PS_ACK: begin
        if (scl_fl) begin
          ld.sda_oe = 1'b0;
          ld.st = PS_RX;
          if (lq.to_tx) begin
            ld.st = PS_TX;
            ld.sh = rd_byte;
            ld.sda_oe = ~rd_byte[7];
          end
        end
      end
      PS_TX: begin
        if (scl_r) begin
          ld.cnt = lq.cnt + 4'h1;
        end
        if (scl_fl) begin
          if (lq.cnt == `BYTE_BITS) begin
            ld.sda_oe = 1'b0;
            ld.st = PS_MACK;
          end else begin
            ld.sh = {lq.sh[6:0], 1'b0};
            ld.sda_oe = ~lq.sh[6];
          end
        end
      end
      PS_MACK: begin
        if (scl_fl) begin
          ld.st = PS_IDLE;
        end
      end
      default: begin
        ld.st = PS_IDLE;
        ld.sda_oe = 1'b0;
      end
    endcase
    if (start_c) begin
      ld.st = PS_RX;
      ld.kind = BK_ADDR;
      ld.cnt = '0;
      ld.sda_oe = 1'b0;
    end
    if (stop_c) begin
      ld.st = PS_IDLE;
      ld.sda_oe = 1'b0;
      if (lq.pending) begin
        ld.commit_tgl = ~lq.commit_tgl;
        ld.pending = 1'b0;
      end
    end
    if (lq.hr_y != lq.hr_p) begin
      ld.hold = bank_defaults();
      ld.pending = 1'b0;
    end
    if (!lq.io_y) begin
      ld.st = PS_IDLE;
      ld.sda_oe = 1'b0;
      ld.pending = 1'b0;
      ld.hold = bank_defaults();
    end
    ld.sda_o = 1'b0;
  end

  always_ff @(posedge link_clk or posedge lrst) begin
    if (lrst) begin
      lq <= '{scl_h: 3'h7, sda_h: 3'h7, scl_m: 1'b1, scl_y: 1'b1, scl_f: 1'b1,
              sda_m: 1'b1, sda_y: 1'b1, sda_f: 1'b1, st: PS_IDLE, kind: BK_ADDR,
              hold: bank_defaults(), default: '0};
    end else begin
      lq <= ld;
    end
  end

  // ****************************************************************
  // Power sequencing, system clock domain
  // ****************************************************************
  // The holding bank is only sampled after the commit toggle has passed two
  // flops; the next write can change it no sooner than a full byte later.
  always_comb begin
    logic tick;
    logic on_state;
    logic en_req;
    logic [5:0] req;
    logic hard;
    logic pg_ok;
    bank_t nb;
    tick = 1'b0;
    on_state = 1'b0;
    en_req = 1'b0;
    req = '0;
    hard = 1'b0;
    pg_ok = 1'b0;
    nb = '0;
    cd = cq;
    cd.pb_m = pushbutton_in_n;
    cd.pb_y = cq.pb_m;
    cd.en_m = enable_pin;
    cd.en_y = cq.en_m;
    cd.io_m = io_supply;
    cd.io_y = cq.io_m;
    cd.cm_m = lq.commit_tgl;
    cd.cm_y = cq.cm_m;
    cd.cm_p = cq.cm_y;
    cd.pg_m = output_in_regulation;
    cd.pg_y = cq.pg_m;
    tick = (cq.div == 16'(TICK_CYCLES - 1));
    cd.div = tick ? 16'h0000 : cq.div + 16'h0001;
    if (cq.cm_y != cq.cm_p) begin
      nb = lq.hold;
      if (nb[`SUB_UVOT][`BIT_RESET_ALL]) begin
        hard = 1'b1;
      end
      cd.cmd = nb;
    end
    req[3:0] = cq.en_y[3:0];
    req[5] = cq.en_y[4];
    for (int i = 0; i < 6; i++) begin
      req[i] = req[i] | cq.cmd[i + 1][`BIT_ENABLE];
    end
    en_req = |req;
    on_state = cq.wake | (|cq.reg_en);
    cd.btn = on_state ? cq.pb_y : 1'b1;
    cd.pb_cnt = tick_count(cq.pb_cnt, ~cq.pb_y, tick);
    if (!on_state && !cq.hr_off) begin
      if (en_req || (tick && cd.pb_cnt == 16'(PRESS_TICKS))) begin
        cd.wake = 1'b1;
      end
    end
    cd.wake_cnt = tick_count(cq.wake_cnt, cq.wake, tick);
    if (cq.wake && cd.wake_cnt >= 16'(WAKE_TICKS)) begin
      cd.wake = 1'b0;
      cd.wake_cnt = '0;
    end
    if (on_state && tick && cd.pb_cnt == 16'(HARD_PRESS_TICKS)) begin
      hard = 1'b1;
    end
    if (hard) begin
      cd.hr_off = 1'b1;
      cd.hr_tgl = ~cq.hr_tgl;
      cd.cmd = bank_defaults();
      cd.wake = 1'b0;
      cd.wake_cnt = '0;
    end
    cd.hr_cnt = tick_count(cq.hr_cnt, cq.hr_off & ~hard, tick);
    if (cq.hr_off && cd.hr_cnt >= 16'(HARD_OFF_TICKS)) begin
      cd.hr_off = 1'b0;
      cd.wake = en_req;
    end
    // enables follow the requests directly, forced off while hard reset is active
    cd.reg_en = (cd.hr_off || hard) ? 6'h00 : req;
    pg_ok = (|cq.reg_en[3:0]) & (&(cq.pg_y | ~cq.reg_en[3:0]));
    cd.por_cnt = tick_count(cq.por_cnt, pg_ok, tick);
    cd.por_n = pg_ok && (cd.por_cnt >= 16'(POR_TICKS));
    if (!cq.io_y) begin
      cd.cmd = bank_defaults();
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cq <= '{pb_m: 1'b1, pb_y: 1'b1, btn: 1'b1, cmd: bank_defaults(), default: '0};
    end else begin
      cq <= cd;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sda_out = lq.sda_o;
  assign sda_oe = lq.sda_oe;
  assign power_hold_out = cq.wake;
  assign button_state_out = cq.btn;
  assign power_on_reset_out_n = cq.por_n;
  assign regulator_en_out = cq.reg_en;
  assign led_brightness_code_out = cq.cmd[`SUB_LED_BRIGHTNESS_CODE];
  assign led_double_scale_out = cq.cmd[`SUB_LED_DRIVE_CONFIG][`BIT_DOUBLE_SCALE];
  assign command_out = cq.cmd;

endmodule : pmic_ctrl

// ==== pmic_ctrl_chk.sv ====
// Concurrent checks on the ports of the power and serial control block.
`timescale 1ns/10ps
module pmic_ctrl_chk
  import pmic_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = 4,
  parameter int WAKE_TICKS = 20,
  parameter int POR_TICKS = 3
) (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic link_clk, // Port clock.
  input wire logic scl_in, // Bus clock.
  input wire logic [3:0] output_in_regulation, // Bucks good.
  input wire logic sda_out, // Data value.
  input wire logic sda_oe, // Data pull.
  input wire logic power_hold_out, // Hold.
  input wire logic button_state_out, // Button.
  input wire logic power_on_reset_out_n, // Reset out.
  input wire logic [5:0] regulator_en_out, // Enables.
  input wire logic [7:0] led_brightness_code_out, // Code.
  input wire logic led_double_scale_out, // Scale.
  input wire bank_t command_out // Latches.
);
  localparam int HOLD_MAX = (WAKE_TICKS + 2) * TICK_CYCLES + 4;
  int hold_cnt_q;
  int off_cnt_q;
  int good_cnt_q;
  logic good;
  // Raw inputs lead the synchronised view, so the count errs on the safe side.
  assign good = (regulator_en_out[3:0] != 4'h0) &&
      ((output_in_regulation | ~regulator_en_out[3:0]) == 4'hf);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_cnt_q <= 0;
      off_cnt_q <= 0;
      good_cnt_q <= 0;
    end else begin
      hold_cnt_q <= power_hold_out ? hold_cnt_q + 1 : 0;
      off_cnt_q <= (power_hold_out || regulator_en_out != 6'h00) ? 0 : off_cnt_q + 1;
      good_cnt_q <= good ? good_cnt_q + 1 : 0;
    end
  end
  hold_len_a: assert property (
    @(posedge clk) disable iff (rst) hold_cnt_q <= HOLD_MAX) else $error("hold too long");
  hold_once_a: assert property (
    @(posedge clk) disable iff (rst) $rose(power_hold_out) |-> $past(regulator_en_out, 4) == 6'h00)
    else $error("hold raised while on");
  off_button_a: assert property (
    @(posedge clk) disable iff (rst) off_cnt_q > 3 |-> button_state_out)
    else $error("button state low while off");
  por_delay_a: assert property (
    @(posedge clk) disable iff (rst)
    $rose(power_on_reset_out_n) |-> good_cnt_q >= (POR_TICKS - 1) * TICK_CYCLES)
    else $error("reset released early");
  por_drop_a: assert property (
    @(posedge clk) disable iff (rst) !good [*6] |-> !power_on_reset_out_n)
    else $error("reset released without regulation");
  led_code_a: assert property (
    @(posedge clk) disable iff (rst) $changed(led_brightness_code_out) |-> scl_in)
    else $error("led code changed while bus clock low");
  led_scale_a: assert property (
    @(posedge clk) disable iff (rst) $changed(led_double_scale_out) |-> scl_in)
    else $error("double scale changed while bus clock low");
  ack_steady_a: assert property (
    @(posedge link_clk) disable iff (rst) sda_oe != $past(sda_oe) |-> !scl_in)
    else $error("data pull changed while clock high");
  sda_low_a: assert property (
    @(posedge link_clk) disable iff (rst) sda_out == 1'b0) else $error("data drive not low");
  hold_c: cover property (@(posedge clk) disable iff (rst) $rose(power_hold_out));
  por_c: cover property (@(posedge clk) disable iff (rst) $rose(power_on_reset_out_n));
  ack_c: cover property (@(posedge link_clk) disable iff (rst) $rose(sda_oe));
endmodule : pmic_ctrl_chk

bind pmic_ctrl pmic_ctrl_chk #(
  .TICK_CYCLES(TICK_CYCLES),
  .WAKE_TICKS(WAKE_TICKS),
  .POR_TICKS(POR_TICKS)
) pmic_ctrl_chk_i (
  .clk(clk), .rst(rst), .link_clk(link_clk), .scl_in(scl_in),
  .output_in_regulation(output_in_regulation), .sda_out(sda_out), .sda_oe(sda_oe),
  .power_hold_out(power_hold_out), .button_state_out(button_state_out),
  .power_on_reset_out_n(power_on_reset_out_n), .regulator_en_out(regulator_en_out),
  .led_brightness_code_out(led_brightness_code_out),
  .led_double_scale_out(led_double_scale_out), .command_out(command_out)
);

// ==== i2c_master_model.sv ====
// Behavioural serial bus master pacing each bit in four quarters of 20 bench clock cycles each.
`timescale 1ns/10ps
module i2c_master_model (
  input wire logic clk, // Pacing clock.
  input wire logic sda_oe, // Device pull.
  output logic scl, // Clock line.
  output logic sda // Resolved data line.
);
  logic sda_m = 1'b1;
  logic smp = 1'b1;
  initial scl = 1'b1;
  // The data line is pulled up; a low from either party wins.
  assign sda = sda_m & ~sda_oe;
  task automatic q();
    repeat (20) @(posedge clk);
  endtask : q
  task automatic pulse();
    q();
    scl <= 1'b1;
    q();
    smp <= sda;
    q();
    scl <= 1'b0;
    q();
  endtask : pulse
  task automatic start_c();
    sda_m <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_m <= 1'b0;
    q();
    scl <= 1'b0;
    q();
  endtask : start_c
  task automatic stop_c();
    sda_m <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_m <= 1'b1;
    q();
  endtask : stop_c
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_m <= b[i];
      pulse();
    end
    sda_m <= 1'b1;
    pulse();
    ack = smp;
  endtask : put_byte
  task automatic get_byte(output logic [7:0] b);
    sda_m <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      pulse();
      b[i] = smp;
    end
    pulse();
  endtask : get_byte
endmodule : i2c_master_model

// ==== testbench.sv ====
// Self-checking bench for the power and serial control block.
`timescale 1ns/10ps
module testbench;
  import pmic_ctrl_pkg::*;
  localparam int TC = 4;
  localparam int WT = 600;
  localparam bank_t DEF = {8'h00, 8'hff, 8'h00, 8'h00, {3{8'h0f}}, {4{8'h6f}}, 8'h00};
  typedef struct packed {
    logic [7:0] sub;
    logic [7:0] dat;
    logic [7:0] exp;
  } row_s;
  localparam row_s [4:0] ROWS = {24'h070808, 24'h08ffff, 24'h0a5a5a, 24'h0c3305, 24'h0e7700};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic link_clk = 1'b0;
  logic pb_n = 1'b1;
  logic [4:0] en_pin = 5'h00;
  logic [3:0] in_reg = 4'h5;
  logic io_sup = 1'b1;
  logic scl, sda, sda_out, sda_oe, hold, btn, por_n, dbl, ack;
  logic [5:0] reg_en;
  logic [7:0] led, rb;
  bank_t cmd;
  int err_total = 0;
  int check_count = 0;
  int n;
  always #25 clk = ~clk;
  initial begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  pmic_ctrl #(.TICK_CYCLES(TC), .PRESS_TICKS(4), .WAKE_TICKS(WT), .HARD_PRESS_TICKS(30),
    .HARD_OFF_TICKS(6), .POR_TICKS(3)) pmic_ctrl_i (
    .clk(clk), .rst(rst), .link_clk(link_clk), .pushbutton_in_n(pb_n), .enable_pin(en_pin),
    .output_in_regulation(in_reg), .io_supply(io_sup), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .power_hold_out(hold), .button_state_out(btn),
    .power_on_reset_out_n(por_n), .regulator_en_out(reg_en), .led_brightness_code_out(led),
    .led_double_scale_out(dbl), .command_out(cmd));
  i2c_master_model i2c_master_model_i (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_byte
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask : cmp_bit
  task automatic pa(input logic [7:0] v, input logic e);
    i2c_master_model_i.put_byte(v, ack);
    cmp_bit(ack, e);
  endtask : pa
  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    i2c_master_model_i.start_c();
    pa(8'h12, 1'b0);
    pa(s, 1'b0);
    pa(d, 1'b0);
    i2c_master_model_i.stop_c();
    repeat (10) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] s, output logic [7:0] d);
    i2c_master_model_i.start_c();
    pa(8'h12, 1'b0);
    pa(s, 1'b0);
    i2c_master_model_i.start_c();
    pa(8'h13, 1'b0);
    i2c_master_model_i.get_byte(d);
    i2c_master_model_i.stop_c();
  endtask : rd
  function automatic logic sig(input int k);
    case (k)
      0: return hold;
      1: return por_n;
      default: return |reg_en;
    endcase
  endfunction : sig
  task automatic wait_sig(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_sig
  task automatic print_verdict();
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // The planned run needs about half of this span.
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    for (int i = 4; i >= 0; i--) begin
      wr(ROWS[i].sub, ROWS[i].dat);
      rd(ROWS[i].sub, rb);
      cmp_byte(rb, ROWS[i].exp);
      if (ROWS[i].sub < 8'h0c) begin
        cmp_byte(cmd[ROWS[i].sub[3:0]], ROWS[i].exp);
      end
    end
    cmp_byte(led, 8'hff);
    cmp_bit(dbl, 1'b1);
    i2c_master_model_i.start_c();
    pa(8'h12, 1'b0);
    pa(8'h08, 1'b0);
    pa(8'h33, 1'b0);
    pa(8'h07, 1'b0);
    pa(8'h00, 1'b0);
    repeat (20) @(posedge clk);
    cmp_byte(led, 8'hff);
    i2c_master_model_i.stop_c();
    repeat (10) @(posedge clk);
    cmp_byte(led, 8'h33);
    cmp_bit(dbl, 1'b0);
    i2c_master_model_i.start_c();
    pa(8'h14, 1'b1);
    i2c_master_model_i.stop_c();
    for (int i = 0; i < 2; i++) begin
      i2c_master_model_i.start_c();
      pa(8'h12, 1'b0);
      pa(i == 0 ? 8'h0f : 8'h00, 1'b0);
      i2c_master_model_i.stop_c();
    end
    cmp_byte(led, 8'h33);
    pb_n <= 1'b0;
    wait_sig(0, 1'b1, 60 * TC);
    cmp_bit(n >= 3 * TC && n <= 6 * TC, 1'b1);
    repeat (4) @(posedge clk);
    cmp_bit(btn, 1'b0);
    pb_n <= 1'b1;
    en_pin <= 5'h01;
    wait_sig(0, 1'b0, WT * TC + 40);
    cmp_bit(n >= (WT - 2) * TC, 1'b1);
    cmp_byte({2'b00, reg_en}, 8'h01);
    en_pin <= 5'h03;
    in_reg <= 4'h3;
    repeat (50) @(posedge clk);
    cmp_bit(hold, 1'b0);
    cmp_bit(por_n, 1'b1);
    pb_n <= 1'b0;
    wait_sig(2, 1'b0, 40 * TC);
    cmp_bit(n >= 28 * TC, 1'b1);
    cmp_byte(cmd[8], 8'h00);
    pb_n <= 1'b1;
    wait_sig(0, 1'b1, 20 * TC);
    cmp_bit(n >= 4 * TC, 1'b1);
    repeat (4) @(posedge clk);
    cmp_byte({2'b00, reg_en}, 8'h03);
    cmp_bit(hold, 1'b1);
    wr(8'h08, 8'h5a);
    wr(8'h09, 8'h80);
    cmp_byte({2'b00, reg_en}, 8'h00);
    cmp_byte(cmd[8], 8'h00);
    wait_sig(0, 1'b1, 20 * TC);
    cmp_bit(hold, 1'b1);
    cmp_byte(cmd[9], 8'h00);
    wr(8'h08, 8'h22);
    io_sup <= 1'b0;
    repeat (20) @(posedge clk);
    io_sup <= 1'b1;
    repeat (20) @(posedge clk);
    cmp_byte(led, 8'h00);
    rd(8'h08, rb);
    cmp_byte(rb, 8'h00);
    wr(8'h08, 8'h5a);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      cmp_byte(cmd[i], DEF[i]);
    end
    cmp_bit(por_n, 1'b0);
    rst <= 1'b0;
    print_verdict();
  end
endmodule : testbench
